// File: accr_pkg.sv
// Package with register map, field layout and types of the channel configuration bank.
package accr_pkg;
   // ==========================================================================
   // Register indices and widths
   // ==========================================================================
   localparam int ADDR_W = 6;
   localparam logic [5:0] GAIN_SEL_ADDR = 6'h04;
   localparam logic [5:0] GLOBAL_CONFIG_ADDR = 6'h06;
   localparam logic [5:0] CHANNEL_INPUT_SELECT_ADDR = 6'h09;
   localparam logic [5:0] OFFSET_TRIM_UPPER_ADDR = 6'h0A;
   localparam logic [5:0] OFFSET_TRIM_LOWER_ADDR = 6'h0B;
   localparam logic [5:0] GAIN_TRIM_UPPER_ADDR = 6'h0C;
   localparam logic [5:0] GAIN_TRIM_LOWER_ADDR = 6'h0D;
   // Slot numbers in the storage module.
   localparam logic [2:0] SLOT_GAIN_SEL = 3'h0;
   localparam logic [2:0] SLOT_CONFIG = 3'h1;
   localparam logic [2:0] SLOT_INPUT = 3'h2;
   localparam logic [2:0] SLOT_OFS_HI = 3'h3;
   localparam logic [2:0] SLOT_OFS_LO = 3'h4;
   localparam logic [2:0] SLOT_GN_HI = 3'h5;
   localparam logic [2:0] SLOT_GN_LO = 3'h6;
   localparam int NUM_SLOTS = 7;
   // ==========================================================================
   // Reset values
   // ==========================================================================
   localparam logic [15:0] GAIN_SEL_RESET = 16'h0000;
   localparam logic [15:0] GLOBAL_CONFIG_RESET = 16'h0600;
   localparam logic [15:0] CHANNEL_INPUT_SELECT_RESET = 16'h0000;
   localparam logic [15:0] OFFSET_TRIM_UPPER_RESET = 16'h0000;
   localparam logic [15:0] OFFSET_TRIM_LOWER_RESET = 16'h0000;
   localparam logic [15:0] GAIN_TRIM_UPPER_RESET = 16'h8000;
   localparam logic [15:0] GAIN_TRIM_LOWER_RESET = 16'h0000;
   // ==========================================================================
   // Field positions
   // ==========================================================================
   localparam int GAIN_CODE_LSB = 0;
   localparam int GAIN_CODE_W = 3;
   localparam int AUX_OE_BIT = 14;
   localparam int AUX_VAL_BIT = 13;
   localparam int CHOP_DLY_LSB = 9;
   localparam int CHOP_DLY_W = 4;
   localparam int CHOP_EN_BIT = 8;
   localparam int INPUT_SEL_LSB = 0;
   localparam int INPUT_SEL_W = 2;
   // Writable masks; the low byte of each lower trim register is read-only zero.
   localparam logic [15:0] TRIM_LOWER_MASK = 16'hFF00;
   localparam logic [15:0] FULL_MASK = 16'hFFFF;
   // ==========================================================================
   // Datapath widths and limits
   // ==========================================================================
   localparam int TRIM_W = 24;
   localparam int SAMPLE_W = 24;
   localparam logic signed [23:0] SAMPLE_MAX = 24'sh7FFFFF;
   localparam logic signed [23:0] SAMPLE_MIN = -24'sh800000;
   // Gain trim unity is 2^23, so products are shifted right by 23.
   localparam int GAIN_FRAC_BITS = 23;
   // Settle delay of 2^(code+1) modulator periods needs 17 bits of count.
   localparam int DLY_CNT_W = 17;

   typedef enum logic [1:0] {
      ACCR_IN_NORMAL = 2'h0,
      ACCR_IN_SHORTED = 2'h1,
      ACCR_IN_DC_DIAG = 2'h2,
      ACCR_IN_AC_DIAG = 2'h3
   } accr_input_t;

   typedef enum logic [2:0] {
      ACCR_ST_IDLE = 3'h1,
      ACCR_ST_SETTLE = 3'h2,
      ACCR_ST_MEASURE = 3'h4
   } accr_chop_state_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [5:0] addr;
      logic [15:0] wdata;
   } accr_bus_req_t;

   typedef struct packed {
      logic [2:0] gain_code;
      logic aux_oe;
      logic aux_val;
      logic [3:0] chop_dly;
      logic chop_en;
      accr_input_t input_sel;
      logic [23:0] offset_trim;
      logic [23:0] gain_trim;
   } accr_cfg_t;
endpackage : accr_pkg

// File: accr_reg_store.sv
// Small register storage with per-slot reset values, write masks and registered read.
`timescale 1ns/1ps
module accr_reg_store (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic wr_i,
   input wire logic [2:0] wr_slot_i,
   input wire logic [15:0] wdata_i,
   input wire logic rd_i,
   input wire logic [2:0] rd_slot_i,
   input wire logic rd_hit_i,
   output logic [15:0] rdata_o,
   output logic [16*accr_pkg::NUM_SLOTS-1:0] flat_o
);
   // ==========================================================================
   // Storage
   // ==========================================================================
   localparam logic [16*accr_pkg::NUM_SLOTS-1:0] RESETS = {
      accr_pkg::GAIN_TRIM_LOWER_RESET, accr_pkg::GAIN_TRIM_UPPER_RESET,
      accr_pkg::OFFSET_TRIM_LOWER_RESET, accr_pkg::OFFSET_TRIM_UPPER_RESET,
      accr_pkg::CHANNEL_INPUT_SELECT_RESET, accr_pkg::GLOBAL_CONFIG_RESET,
      accr_pkg::GAIN_SEL_RESET};
   localparam logic [16*accr_pkg::NUM_SLOTS-1:0] MASKS = {
      accr_pkg::TRIM_LOWER_MASK, accr_pkg::FULL_MASK, accr_pkg::TRIM_LOWER_MASK,
      accr_pkg::FULL_MASK, accr_pkg::FULL_MASK, accr_pkg::FULL_MASK, accr_pkg::FULL_MASK};
   logic [15:0] mem [accr_pkg::NUM_SLOTS];

   // One flop word per slot; masked bits never store so they always read zero.
   genvar g;
   generate
      for (g = 0; g < accr_pkg::NUM_SLOTS; g++) begin : g_slot
         always_ff @(posedge ref_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
               mem[g] <= RESETS[16*g +: 16];
            end else if (wr_i && wr_slot_i == 3'(g)) begin
               mem[g] <= wdata_i & MASKS[16*g +: 16];
            end
         end
         assign flat_o[16*g +: 16] = mem[g];
      end
   endgenerate

   // Read data are registered; unmapped addresses read zero.
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_o <= 16'h0000;
      end else if (rd_i) begin
         rdata_o <= rd_hit_i ? mem[rd_slot_i] : 16'h0000;
      end
   end
endmodule : accr_reg_store

// File: accr_top.sv
// Channel configuration and calibration register bank with correction datapath.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module accr_top (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic [5:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [15:0] reg_rdata_o,
   input wire logic mod_tick_i,
   input wire logic chop_swap_i,
   input wire logic sample_valid_i,
   input wire logic signed [23:0] sample_i,
   output logic signed [23:0] result_o,
   output logic result_valid_o,
   output logic [2:0] gain_code_o,
   output logic [7:0] gain_factor_o,
   output logic [1:0] input_select_o,
   output logic chop_enable_o,
   output logic measure_enable_o,
   input wire logic spare_input_pin_i,
   output logic spare_pin_output_o,
   output logic spare_pin_oe_o,
   output logic spare_pin_analog_o
);
   // ==========================================================================
   // Address decode
   // ==========================================================================
   accr_pkg::accr_bus_req_t req;
   accr_pkg::accr_cfg_t cfg;
   logic [16*accr_pkg::NUM_SLOTS-1:0] flat;
   logic [2:0] wr_slot;
   logic [2:0] rd_slot;
   logic wr_hit;
   logic rd_hit;

   // Map a bus address to a storage slot; used for both reads and writes.
   function automatic logic [3:0] decode_slot(input logic [5:0] a);
      case (a)
         accr_pkg::GAIN_SEL_ADDR: decode_slot = {1'b1, accr_pkg::SLOT_GAIN_SEL};
         accr_pkg::GLOBAL_CONFIG_ADDR: decode_slot = {1'b1, accr_pkg::SLOT_CONFIG};
         accr_pkg::CHANNEL_INPUT_SELECT_ADDR: decode_slot = {1'b1, accr_pkg::SLOT_INPUT};
         accr_pkg::OFFSET_TRIM_UPPER_ADDR: decode_slot = {1'b1, accr_pkg::SLOT_OFS_HI};
         accr_pkg::OFFSET_TRIM_LOWER_ADDR: decode_slot = {1'b1, accr_pkg::SLOT_OFS_LO};
         accr_pkg::GAIN_TRIM_UPPER_ADDR: decode_slot = {1'b1, accr_pkg::SLOT_GN_HI};
         accr_pkg::GAIN_TRIM_LOWER_ADDR: decode_slot = {1'b1, accr_pkg::SLOT_GN_LO};
         default: decode_slot = 4'h0;
      endcase
   endfunction : decode_slot

   // Bundle the bus request and decode it.
   assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i, wdata: reg_wdata_i};
   assign {wr_hit, wr_slot} = decode_slot(req.addr);
   assign {rd_hit, rd_slot} = decode_slot(req.addr);

   // Reserved bits are stored as written; the host keeps them zero.
   accr_reg_store u_store (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .wr_i(req.wr && wr_hit),
      .wr_slot_i(wr_slot),
      .wdata_i(req.wdata),
      .rd_i(req.rd),
      .rd_slot_i(rd_slot),
      .rd_hit_i(rd_hit),
      .rdata_o(reg_rdata_o),
      .flat_o(flat)
   );

   // ==========================================================================
   // Field extraction
   // ==========================================================================
   logic [15:0] w_gsel;
   logic [15:0] w_cfg;
   logic [15:0] w_in;
   assign w_gsel = flat[16*accr_pkg::SLOT_GAIN_SEL +: 16];
   assign w_cfg = flat[16*accr_pkg::SLOT_CONFIG +: 16];
   assign w_in = flat[16*accr_pkg::SLOT_INPUT +: 16];

   // Pull every control field out of the stored words.
   always_comb begin
      cfg.gain_code = w_gsel[accr_pkg::GAIN_CODE_LSB +: accr_pkg::GAIN_CODE_W];
      cfg.aux_oe = w_cfg[accr_pkg::AUX_OE_BIT];
      cfg.aux_val = w_cfg[accr_pkg::AUX_VAL_BIT];
      cfg.chop_dly = w_cfg[accr_pkg::CHOP_DLY_LSB +: accr_pkg::CHOP_DLY_W];
      cfg.chop_en = w_cfg[accr_pkg::CHOP_EN_BIT];
      cfg.input_sel = accr_pkg::accr_input_t'(w_in[accr_pkg::INPUT_SEL_LSB +:
                                                   accr_pkg::INPUT_SEL_W]);
      cfg.offset_trim = {flat[16*accr_pkg::SLOT_OFS_HI +: 16],
                         flat[16*accr_pkg::SLOT_OFS_LO + 8 +: 8]};
      cfg.gain_trim = {flat[16*accr_pkg::SLOT_GN_HI +: 16],
                       flat[16*accr_pkg::SLOT_GN_LO + 8 +: 8]};
   end

   // ==========================================================================
   // Control outputs and spare pin
   // ==========================================================================
   // Control outputs follow the stored fields directly, with no extra latency.
   assign gain_code_o = cfg.gain_code;
   assign gain_factor_o = 8'h01 << cfg.gain_code;
   assign input_select_o = cfg.input_sel;
   assign chop_enable_o = cfg.chop_en;
   // The pin is analog unless enabled; the analog path sees the pin level.
   assign spare_pin_oe_o = cfg.aux_oe;
   assign spare_pin_output_o = cfg.aux_oe & cfg.aux_val;
   assign spare_pin_analog_o = cfg.aux_oe ? 1'b0 : spare_input_pin_i;

   // ==========================================================================
   // Global-chop settle sequencer
   // ==========================================================================
   accr_pkg::accr_chop_state_t state;
   logic [16:0] dly_cnt;
   logic [16:0] dly_target;
   assign dly_target = 17'(17'h00002 << cfg.chop_dly) - 17'h00001;

   // A swap during measurement starts the wait; swaps while settling are ignored; a disabled chop measures continuously.
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state <= accr_pkg::ACCR_ST_MEASURE;
         dly_cnt <= 17'h00000;
      end else begin
         case (state)
            accr_pkg::ACCR_ST_IDLE: begin
               state <= accr_pkg::ACCR_ST_MEASURE;
            end
            accr_pkg::ACCR_ST_SETTLE: begin
               if (!cfg.chop_en) begin
                  state <= accr_pkg::ACCR_ST_MEASURE;
               end else if (mod_tick_i) begin
                  if (dly_cnt == dly_target) begin
                     state <= accr_pkg::ACCR_ST_MEASURE;
                  end
                  dly_cnt <= dly_cnt + 17'h00001;
               end
            end
            accr_pkg::ACCR_ST_MEASURE: begin
               if (cfg.chop_en && chop_swap_i) begin
                  state <= accr_pkg::ACCR_ST_SETTLE;
                  dly_cnt <= 17'h00000;
               end
            end
            default: begin
               state <= accr_pkg::ACCR_ST_MEASURE;
            end
         endcase
      end
   end
   assign measure_enable_o = (state == accr_pkg::ACCR_ST_MEASURE);

   // ==========================================================================
   // Calibration datapath
   // ==========================================================================
   logic signed [24:0] diff;
   logic signed [50:0] prod;
   logic signed [50:0] scaled;
   assign diff = 25'(sample_i) - 25'(signed'(cfg.offset_trim));
   assign prod = 51'(diff) * 51'(signed'({1'b0, cfg.gain_trim}));
   assign scaled = prod >>> accr_pkg::GAIN_FRAC_BITS;

   // Saturate into the 24-bit signed result; samples during settling are dropped.
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         result_o <= 24'sh000000;
         result_valid_o <= 1'b0;
      end else begin
         result_valid_o <= sample_valid_i && measure_enable_o;
         if (sample_valid_i && measure_enable_o) begin
            if (scaled > 51'(accr_pkg::SAMPLE_MAX)) begin
               result_o <= accr_pkg::SAMPLE_MAX;
            end else if (scaled < 51'(accr_pkg::SAMPLE_MIN)) begin
               result_o <= accr_pkg::SAMPLE_MIN;
            end else begin
               result_o <= scaled[23:0];
            end
         end
      end
   end

   // ==========================================================================
   // Assertions
   // ==========================================================================
   property p_gain_factor;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         gain_factor_o == (8'h01 << reg_store_gain_code());
   endproperty
   function automatic logic [2:0] reg_store_gain_code();
      reg_store_gain_code = flat[16*accr_pkg::SLOT_GAIN_SEL +: 3];
   endfunction : reg_store_gain_code
   a_gain_factor: assert property (p_gain_factor) else $error("gain factor wrong");

   property p_gain_write;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         reg_wr_i && reg_addr_i == accr_pkg::GAIN_SEL_ADDR
         |=> gain_code_o == $past(reg_wdata_i[2:0]);
   endproperty
   a_gain_write: assert property (p_gain_write) else $error("gain code not written");

   property p_pin_off;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         !spare_pin_oe_o |-> !spare_pin_output_o;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("pin driven while input");

   property p_pin_value;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         reg_wr_i && reg_addr_i == accr_pkg::GLOBAL_CONFIG_ADDR && reg_wdata_i[14]
         |=> spare_pin_oe_o && spare_pin_output_o == $past(reg_wdata_i[13]);
   endproperty
   a_pin_value: assert property (p_pin_value) else $error("pin value wrong");

   // The shortest settle is two ticks, so the first tick of any wait never ends it.
   property p_settle_min;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         state == accr_pkg::ACCR_ST_SETTLE && cfg.chop_en && mod_tick_i && dly_cnt == 17'h00000
         |=> state == accr_pkg::ACCR_ST_SETTLE;
   endproperty
   a_settle_min: assert property (p_settle_min) else $error("settle ended early");

   property p_chop_off;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         !cfg.chop_en |=> measure_enable_o;
   endproperty
   a_chop_off: assert property (p_chop_off) else $error("settle without chop");

   property p_ofs_low_zero;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         reg_rd_i && reg_addr_i == accr_pkg::OFFSET_TRIM_LOWER_ADDR |=> reg_rdata_o[7:0] == 8'h00;
   endproperty
   a_ofs_low_zero: assert property (p_ofs_low_zero) else $error("offset low byte set");

   property p_ofs_hi;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         reg_wr_i && reg_addr_i == accr_pkg::OFFSET_TRIM_UPPER_ADDR
         |=> cfg.offset_trim[23:8] == $past(reg_wdata_i);
   endproperty
   a_ofs_hi: assert property (p_ofs_hi) else $error("offset upper not stored");

   property p_gain_low;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         reg_wr_i && reg_addr_i == accr_pkg::GAIN_TRIM_LOWER_ADDR
         |=> cfg.gain_trim[7:0] == $past(reg_wdata_i[15:8]) && flat[16*6 +: 8] == 8'h00;
   endproperty
   a_gain_low: assert property (p_gain_low) else $error("gain low byte wrong");

   property p_unity;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         sample_valid_i && measure_enable_o && cfg.gain_trim == 24'h800000
         && cfg.offset_trim == 24'h000000 |=> result_o == $past(sample_i) && result_valid_o;
   endproperty
   a_unity: assert property (p_unity) else $error("unity gain changed sample");

   // The tick that completes the selected number of periods returns to measurement.
   property p_settle_end;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         state == accr_pkg::ACCR_ST_SETTLE && cfg.chop_en && mod_tick_i
         && dly_cnt == (17'h00002 << cfg.chop_dly) - 17'h00001 |=> measure_enable_o;
   endproperty
   a_settle_end: assert property (p_settle_end) else $error("settle did not end");

   property p_settle_drop;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         sample_valid_i && !measure_enable_o |=> !result_valid_o;
   endproperty
   a_settle_drop: assert property (p_settle_drop) else $error("sample kept in settle");

   property p_chop_write;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         reg_wr_i && reg_addr_i == accr_pkg::GLOBAL_CONFIG_ADDR
         |=> chop_enable_o == $past(reg_wdata_i[accr_pkg::CHOP_EN_BIT]);
   endproperty
   a_chop_write: assert property (p_chop_write) else $error("chop enable not written");

   property p_analog_cut;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         spare_pin_oe_o |-> !spare_pin_analog_o;
   endproperty
   a_analog_cut: assert property (p_analog_cut) else $error("analog path sees driven pin");

   property p_input_write;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         reg_wr_i && reg_addr_i == accr_pkg::CHANNEL_INPUT_SELECT_ADDR
         |=> input_select_o == $past(reg_wdata_i[1:0]);
   endproperty
   a_input_write: assert property (p_input_write) else $error("input select wrong");

   property p_ofs_lo;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         reg_wr_i && reg_addr_i == accr_pkg::OFFSET_TRIM_LOWER_ADDR
         |=> cfg.offset_trim[7:0] == $past(reg_wdata_i[15:8]);
   endproperty
   a_ofs_lo: assert property (p_ofs_lo) else $error("offset low byte not stored");

   property p_gain_hi;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         reg_wr_i && reg_addr_i == accr_pkg::GAIN_TRIM_UPPER_ADDR
         |=> cfg.gain_trim[23:8] == $past(reg_wdata_i);
   endproperty
   a_gain_hi: assert property (p_gain_hi) else $error("gain upper not stored");
endmodule : accr_top

// File: accr_testbench.sv
// Self-checking testbench for the channel configuration and calibration register bank.
`timescale 1ns/1ps
module testbench;
   // ==========================================================================
   // Clock, reset and stimulus signals
   // ==========================================================================
   logic ref_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [5:0] reg_addr_i = 6'h00;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [15:0] reg_rdata_o;
   logic mod_tick_i = 1'b0;
   logic chop_swap_i = 1'b0;
   logic sample_valid_i = 1'b0;
   logic signed [23:0] sample_i = 24'h000000;
   logic signed [23:0] result_o;
   logic result_valid_o;
   logic [2:0] gain_code_o;
   logic [7:0] gain_factor_o;
   logic [1:0] input_select_o;
   logic chop_enable_o;
   logic measure_enable_o;
   logic spare_input_pin_i = 1'b0;
   logic spare_pin_output_o;
   logic spare_pin_oe_o;
   logic spare_pin_analog_o;
   int errors = 0;
   int cmp_count = 0;
   logic [15:0] rd_val;

   // A 25 ns period gives the 40 MHz reference clock.
   always #12.5 ref_clk_i = ~ref_clk_i;

   accr_top u_dut (
      .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .mod_tick_i(mod_tick_i), .chop_swap_i(chop_swap_i),
      .sample_valid_i(sample_valid_i), .sample_i(sample_i), .result_o(result_o),
      .result_valid_o(result_valid_o), .gain_code_o(gain_code_o),
      .gain_factor_o(gain_factor_o), .input_select_o(input_select_o),
      .chop_enable_o(chop_enable_o), .measure_enable_o(measure_enable_o),
      .spare_input_pin_i(spare_input_pin_i), .spare_pin_output_o(spare_pin_output_o),
      .spare_pin_oe_o(spare_pin_oe_o), .spare_pin_analog_o(spare_pin_analog_o)
   );

   // ==========================================================================
   // Reporting and bus tasks
   // ==========================================================================
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // A write is taken at the edge that sees the strobe; outputs settle just after it.
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
      #1;
   endtask : wr

   // Read data load at the edge that sees the strobe and hold until the next read, so they are caught just after it.
   task automatic rd(input logic [5:0] a, output logic [15:0] d);
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      #1;
      d = reg_rdata_o;
   endtask : rd

   // One-cycle pulse on the chop swap input when swap is set, else on the modulator tick.
   task automatic pulse(input logic swap);
      @(posedge ref_clk_i);
      if (swap) chop_swap_i <= 1'b1;
      else mod_tick_i <= 1'b1;
      @(posedge ref_clk_i);
      chop_swap_i <= 1'b0;
      mod_tick_i <= 1'b0;
      #1;
   endtask : pulse

   // Expected correction: remove the offset, scale by the unsigned trim, clamp.
   function automatic logic [23:0] corrected(input logic [23:0] s, input logic [23:0] o,
                                             input logic [23:0] g);
      longint d;
      longint p;
      d = longint'($signed(s)) - longint'($signed(o));
      p = (d * longint'({40'h0, g})) >>> 23;
      if (p > 64'sh7FFFFF) p = 64'sh7FFFFF;
      if (p < -64'sh800000) p = -64'sh800000;
      return p[23:0];
   endfunction : corrected

   // A sample presented for one cycle; the caller looks at the result just after.
   task automatic samp(input logic [23:0] s);
      @(posedge ref_clk_i);
      sample_valid_i <= 1'b1;
      sample_i <= s;
      @(posedge ref_clk_i);
      sample_valid_i <= 1'b0;
      #1;
   endtask : samp

   // ==========================================================================
   // Register map as the bank should present it
   // ==========================================================================
   logic [5:0] ra [7] = '{accr_pkg::GAIN_SEL_ADDR, accr_pkg::GLOBAL_CONFIG_ADDR,
      accr_pkg::CHANNEL_INPUT_SELECT_ADDR, accr_pkg::OFFSET_TRIM_UPPER_ADDR,
      accr_pkg::OFFSET_TRIM_LOWER_ADDR, accr_pkg::GAIN_TRIM_UPPER_ADDR,
      accr_pkg::GAIN_TRIM_LOWER_ADDR};
   logic [15:0] rst [7] = '{16'h0000, 16'h0600, 16'h0000, 16'h0000, 16'h0000, 16'h8000,
      16'h0000};
   // Only documented fields are written; read-only low bytes are written to prove them.
   logic [15:0] wm [7] = '{16'h0007, 16'h7F00, 16'h0003, 16'hFFFF, 16'hFFFF, 16'hFFFF,
      16'hFFFF};
   logic [15:0] rm [7] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFF00, 16'hFFFF,
      16'hFF00};

   // A hang anywhere ends the run through the same closing report.
   initial begin
      #(25ns * 100000);
      errors++;
      give_verdict();
   end

   // ==========================================================================
   // Main sequence
   // ==========================================================================
   initial begin
      logic [15:0] d;
      logic [23:0] s, o, g;
      int n;
      void'($urandom(32'hd3ce));
      repeat (20) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      chk(measure_enable_o, 1'b1);
      // Reset values, then random writes read back through each field mask.
      for (int i = 0; i < 7; i++) begin
         rd(ra[i], rd_val); chk(rd_val, rst[i]);
         d = 16'($urandom()) & wm[i];
         wr(ra[i], d);
         rd(ra[i], rd_val); chk(rd_val, d & rm[i]);
      end
      wr(6'h3F, 16'hFFFF);
      rd(6'h3F, rd_val); chk(rd_val, 16'h0000);
      // Every gain code and every input source.
      for (int c = 0; c < 8; c++) begin
         wr(accr_pkg::GAIN_SEL_ADDR, 16'(c));
         chk(gain_code_o, c);
         chk(gain_factor_o, 1 << c);
      end
      for (int c = 0; c < 4; c++) begin
         wr(accr_pkg::CHANNEL_INPUT_SELECT_ADDR, 16'(c));
         chk(input_select_o, c);
      end
      // Spare pin in each enable and level combination, with a wandering pin level.
      for (int c = 0; c < 4; c++) begin
         spare_input_pin_i <= 1'($urandom());
         wr(accr_pkg::GLOBAL_CONFIG_ADDR, {1'b0, 2'(c), 13'h0600});
         chk(spare_pin_oe_o, c[1]);
         if (c[1]) chk(spare_pin_output_o, c[0]);
         chk(spare_pin_analog_o, c[1] ? 1'b0 : spare_input_pin_i);
      end
      // Settling after a chop swap lasts a power of two of modulator ticks.
      for (int k = 0; k < 3; k++) begin
         n = (k == 0) ? 0 : (k == 1) ? 2 : 5;
         wr(accr_pkg::GLOBAL_CONFIG_ADDR, 16'((n << 9) | 16'h0100));
         chk(chop_enable_o, 1'b1);
         pulse(1'b1);
         chk(measure_enable_o, 1'b0);
         samp(24'h000123);
         chk(result_valid_o, 1'b0);
         for (int t = 1; t <= 200; t++) begin
            pulse(1'b0);
            @(posedge ref_clk_i);
            #1;
            if (measure_enable_o === 1'b1) begin
               chk(t, 1 << (n + 1));
               break;
            end
            if (t == 200) begin
               errors++;
               give_verdict();
            end
         end
      end
      // With chop off, a swap must not stop measurement.
      wr(accr_pkg::GLOBAL_CONFIG_ADDR, 16'h0000);
      chk(chop_enable_o, 1'b0);
      pulse(1'b1);
      chk(measure_enable_o, 1'b1);
      // A reset in mid-settle brings back the reset values and measurement.
      wr(accr_pkg::GLOBAL_CONFIG_ADDR, 16'h0100);
      pulse(1'b1);
      chk(measure_enable_o, 1'b0);
      @(posedge ref_clk_i);
      rstn_i <= 1'b0;
      @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      #1;
      chk(measure_enable_o, 1'b1);
      rd(accr_pkg::GLOBAL_CONFIG_ADDR, rd_val);
      chk(rd_val, 16'h0600);
      rd(accr_pkg::GAIN_TRIM_UPPER_ADDR, rd_val);
      chk(rd_val, 16'h8000);
      // Corrected samples: unity, both saturation limits, then random trims.
      for (int i = 0; i < 24; i++) begin
         s = 24'($urandom());
         o = (i < 3) ? 24'h000000 : 24'($urandom());
         g = 24'($urandom());
         if (i == 0) g = 24'h800000;
         if (i == 1) begin
            s = 24'h7FFFFF; o = 24'h800000; g = 24'hFFFFFF;
         end
         if (i == 2) begin
            s = 24'h800000; o = 24'h7FFFFF; g = 24'hFFFFFF;
         end
         wr(accr_pkg::OFFSET_TRIM_UPPER_ADDR, o[23:8]);
         wr(accr_pkg::OFFSET_TRIM_LOWER_ADDR, {o[7:0], 8'h00});
         wr(accr_pkg::GAIN_TRIM_UPPER_ADDR, g[23:8]);
         wr(accr_pkg::GAIN_TRIM_LOWER_ADDR, {g[7:0], 8'h00});
         samp(s);
         chk(result_valid_o, 1'b1);
         chk(result_o[23:0], corrected(s, o, g));
      end
      give_verdict();
   end
endmodule : testbench
